// ---- logic/rxf_framer.v ----
// receive indication framer: rf packet in, framed byte stream out
`timescale 1ns/1ns
`include "rxf_defs.vh"

// How it works
// R1 - format select 0 gives a standard frame, type byte 0x90
// R2 - format select 1 gives an explicit frame, type byte 0x91
// R3 - envelope: 0x7E, length msb first, body, one checksum byte
// R4 - standard frame: 64-bit source address bytes 4-11, msb first
// R5 - both formats: 16-bit network address bytes 12-13, msb first
// R6 - standard byte 14 options: ack, broadcast, encrypted, end device
// R7 - applicable option flags are ORed into one byte
// R8 - standard frame payload follows in order from byte 15
// R9 - explicit frame: 64-bit source address bytes 4-11, msb first
// R10 - explicit frame: source endpoint byte 14, destination byte 15
// R11 - explicit: cluster id bytes 16-17, profile id 18-19, msb first
// R12 - explicit options at byte 20 without end-device flag; payload 21 on
// R13 - length counts frame-type byte through last payload byte
// R14 - checksum is 0xFF minus low byte of the summed body bytes
module rxf_framer #(
    parameter LEN_W = 16
) (
    input wire mclk,
    input wire rst_n,
    input wire rx_indicator_format_select,
    // packet header, sampled with pkt_start
    input wire pkt_start,
    output wire pkt_start_ready,
    input wire [63:0] src_addr64,
    input wire [15:0] src_addr16,
    input wire [7:0] src_endpoint,
    input wire [7:0] dst_endpoint,
    input wire [15:0] cluster_id,
    input wire [15:0] profile_id,
    input wire opt_ack,
    input wire opt_bcast,
    input wire opt_enc,
    input wire opt_enddev,
    input wire [LEN_W-1:0] pay_len,
    // payload stream
    input wire pay_valid,
    input wire [7:0] pay_data,
    output wire pay_ready,
    // framed byte stream toward the serial link
    output reg out_valid,
    output reg [7:0] out_data,
    output reg out_last,
    input wire out_ready
);

// ======================================================
// state machine
localparam [5:0] S_IDLE = 6'b000001;
localparam [5:0] S_DELIM = 6'b000010;
localparam [5:0] S_LEN = 6'b000100;
localparam [5:0] S_HDR = 6'b001000;
localparam [5:0] S_PAY = 6'b010000;
localparam [5:0] S_CSUM = 6'b100000;

reg [5:0] state;
reg [5:0] next_state;
reg expl;
reg [63:0] a64;
reg [15:0] a16;
reg [7:0] sep;
reg [7:0] dep;
reg [15:0] clu;
reg [15:0] pro;
reg [7:0] opts;
reg [LEN_W-1:0] plen;
reg [LEN_W-1:0] pcnt;
reg [4:0] idx;
reg len_lo;
reg [7:0] sum;
reg [LEN_W-1:0] body_len;
reg [7:0] cur_byte;
reg cur_valid;
reg cur_last;
reg [7:0] hdr_byte;
reg [7:0] opt_byte;
reg [7:0] csum_byte;

wire slot_free;
wire take;
wire [4:0] last_hdr;
wire hdr_take;
wire [7:0] a64_lane [0:7];

// output stage is one register; it refills when empty or being taken
assign slot_free = !out_valid || out_ready;
assign take = cur_valid && slot_free;
assign pkt_start_ready = (state == S_IDLE);
assign hdr_take = (state == S_IDLE) && pkt_start;
// payload is only asked for when the output slot can take it
assign pay_ready = (state == S_PAY) && slot_free;
assign last_hdr = expl ? `RXF_LAST_HDR_EXP : `RXF_LAST_HDR_STD;

// ======================================================
// options byte
always @* begin
    opt_byte = `RXF_OPT_NONE; // see R7
    if (opt_ack) begin
        opt_byte = opt_byte | `RXF_OPT_ACK; // see R6
    end
    if (opt_bcast) begin
        opt_byte = opt_byte | `RXF_OPT_BCAST;
    end
    if (opt_enc) begin
        opt_byte = opt_byte | `RXF_OPT_ENC;
    end
    // explicit frames never report the end-device flag
    if (opt_enddev && (rx_indicator_format_select != `RXF_SEL_EXP)) begin
        opt_byte = opt_byte | `RXF_OPT_ENDDEV; // see R12
    end
end

// ======================================================
// source address byte lanes, lane 0 is sent first
// lanes keep the wire order out of the byte mux
genvar g;
generate
    for (g = 0; g < 8; g = g + 1) begin : g_lane
        assign a64_lane[g] = a64[63-8*g -: 8]; // see R4 R9
    end
endgenerate

// ======================================================
// header byte selection, idx 0 is the frame-type byte
always @* begin
    hdr_byte = `RXF_OPT_NONE;
    case (idx)
        `RXF_P_TYPE: begin
            hdr_byte = expl ? `RXF_TYPE_EXP : `RXF_TYPE_STD; // see R1 R2
        end
        `RXF_P_A64_0: hdr_byte = a64_lane[0]; // see R4 R9
        `RXF_P_A64_1: hdr_byte = a64_lane[1];
        `RXF_P_A64_2: hdr_byte = a64_lane[2];
        `RXF_P_A64_3: hdr_byte = a64_lane[3];
        `RXF_P_A64_4: hdr_byte = a64_lane[4];
        `RXF_P_A64_5: hdr_byte = a64_lane[5];
        `RXF_P_A64_6: hdr_byte = a64_lane[6];
        `RXF_P_A64_7: hdr_byte = a64_lane[7];
        `RXF_P_A16_HI: hdr_byte = a16[15:8]; // see R5
        `RXF_P_A16_LO: hdr_byte = a16[7:0];
        `RXF_P_OPT_SEP: hdr_byte = expl ? sep : opts; // see R6 R10
        `RXF_P_DEP: hdr_byte = dep; // see R10
        `RXF_P_CLU_HI: hdr_byte = clu[15:8]; // see R11
        `RXF_P_CLU_LO: hdr_byte = clu[7:0];
        `RXF_P_PRO_HI: hdr_byte = pro[15:8];
        `RXF_P_PRO_LO: hdr_byte = pro[7:0];
        `RXF_P_OPT_EXP: hdr_byte = opts; // see R12
        default: hdr_byte = `RXF_OPT_NONE;
    endcase
end

// ======================================================
// envelope arithmetic
// length wraps if pay_len plus header overflows; the source keeps it short
always @* begin
    body_len = plen + (expl ? `RXF_HDR_EXP : `RXF_HDR_STD); // see R13
    csum_byte = `RXF_CSUM_BASE - sum; // see R14
end

// ======================================================
// byte producer
always @* begin
    cur_byte = `RXF_OPT_NONE;
    cur_valid = 1'b0;
    cur_last = 1'b0;
    next_state = state;
    case (state)
        S_IDLE: begin
            if (pkt_start) begin
                next_state = S_DELIM;
            end
        end
        S_DELIM: begin
            cur_byte = `RXF_START_DELIM; // see R3
            cur_valid = 1'b1;
            if (slot_free) begin
                next_state = S_LEN;
            end
        end
        S_LEN: begin
            cur_byte = len_lo ? body_len[7:0] : body_len[15:8]; // see R3
            cur_valid = 1'b1;
            if (slot_free && len_lo) begin
                next_state = S_HDR;
            end
        end
        S_HDR: begin
            cur_byte = hdr_byte;
            cur_valid = 1'b1;
            // an empty payload goes straight to the checksum
            if (slot_free && idx == last_hdr) begin
                next_state = (plen == {LEN_W{1'b0}}) ? S_CSUM : S_PAY;
            end
        end
        S_PAY: begin
            cur_byte = pay_data; // see R8 R12
            // a gap on pay_valid just leaves the output slot empty
            cur_valid = pay_valid;
            if (take && pcnt == plen - 1'b1) begin
                next_state = S_CSUM;
            end
        end
        S_CSUM: begin
            cur_byte = csum_byte; // see R14
            cur_valid = 1'b1;
            cur_last = 1'b1;
            if (slot_free) begin
                next_state = S_IDLE;
            end
        end
        default: next_state = S_IDLE;
    endcase
end

// ======================================================
// state register
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        state <= S_IDLE;
    end else begin
        state <= next_state;
    end
end

// ======================================================
// packet header capture
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        expl <= 1'b0;
        a64 <= 64'h0000_0000_0000_0000;
        a16 <= 16'h0000;
        sep <= 8'h00;
        dep <= 8'h00;
        clu <= 16'h0000;
        pro <= 16'h0000;
        opts <= 8'h00;
        plen <= {LEN_W{1'b0}};
    end else if (hdr_take) begin
        // format latched per packet so a mid-frame change is harmless
        // flags folded into one byte here, so they may drop after the take
        expl <= rx_indicator_format_select; // see R1 R2
        a64 <= src_addr64;
        a16 <= src_addr16;
        sep <= src_endpoint;
        dep <= dst_endpoint;
        clu <= cluster_id;
        pro <= profile_id;
        opts <= opt_byte; // see R7
        plen <= pay_len;
    end
end

// ======================================================
// frame position counters and running body sum
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        pcnt <= {LEN_W{1'b0}};
        idx <= `RXF_P_TYPE;
        len_lo <= 1'b0;
        sum <= 8'h00;
    end else if (hdr_take) begin
        // cleared at every take so a frame never inherits old counts
        pcnt <= {LEN_W{1'b0}};
        idx <= `RXF_P_TYPE;
        len_lo <= 1'b0;
        sum <= 8'h00;
    end else if (take) begin
        if (state == S_LEN) begin
            len_lo <= 1'b1;
        end
        if (state == S_HDR) begin
            idx <= idx + `RXF_P_STEP;
        end
        if (state == S_PAY) begin
            pcnt <= pcnt + 1'b1;
        end
        // delimiter and length bytes stay out of the sum
        if (state == S_HDR || state == S_PAY) begin
            sum <= sum + cur_byte; // see R14
        end
    end
end

// ======================================================
// output stage
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        out_valid <= 1'b0;
        out_data <= 8'h00;
        out_last <= 1'b0;
    end else if (slot_free) begin
        // a stalled byte holds until the sink takes it
        out_valid <= cur_valid;
        out_data <= cur_byte;
        out_last <= cur_last;
    end
end

endmodule // rxf_framer

// ---- inc/rxf_defs.vh ----
// constants for the receive indication framer
`ifndef RXF_DEFS_VH
`define RXF_DEFS_VH

`define RXF_START_DELIM 8'h7E
`define RXF_TYPE_STD 8'h90
`define RXF_TYPE_EXP 8'h91
`define RXF_OPT_ACK 8'h01
`define RXF_OPT_BCAST 8'h02
`define RXF_OPT_ENC 8'h20
`define RXF_OPT_ENDDEV 8'h40
`define RXF_OPT_NONE 8'h00
`define RXF_CSUM_BASE 8'hFF
// header bytes after the length field, excluding payload
`define RXF_HDR_STD 16'h000C
`define RXF_HDR_EXP 16'h0012
// last header byte index counted from the frame-type byte
`define RXF_LAST_HDR_STD 5'h0B
`define RXF_LAST_HDR_EXP 5'h11
`define RXF_SEL_EXP 1'b1
// header byte positions counted from the frame-type byte
`define RXF_P_TYPE 5'h00
`define RXF_P_A64_0 5'h01
`define RXF_P_A64_1 5'h02
`define RXF_P_A64_2 5'h03
`define RXF_P_A64_3 5'h04
`define RXF_P_A64_4 5'h05
`define RXF_P_A64_5 5'h06
`define RXF_P_A64_6 5'h07
`define RXF_P_A64_7 5'h08
`define RXF_P_A16_HI 5'h09
`define RXF_P_A16_LO 5'h0A
`define RXF_P_OPT_SEP 5'h0B
`define RXF_P_DEP 5'h0C
`define RXF_P_CLU_HI 5'h0D
`define RXF_P_CLU_LO 5'h0E
`define RXF_P_PRO_HI 5'h0F
`define RXF_P_PRO_LO 5'h10
`define RXF_P_OPT_EXP 5'h11
`define RXF_P_STEP 5'h01

`endif

// ---- dv/rxf_props.sv ----
// assertions for the receive indication framer
`timescale 1ns/1ns
module rxf_props (
    input wire mclk,
    input wire rst_n,
    input wire pkt_start,
    input wire pkt_start_ready,
    input wire pay_ready,
    input wire pay_valid,
    input wire [7:0] pay_data,
    input wire out_valid,
    input wire [7:0] out_data,
    input wire out_last,
    input wire out_ready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // byte index within a frame, captured length, running body sum
    logic [15:0] idx, len;
    logic [7:0] sum;
    wire acc = out_valid && out_ready;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            idx <= 16'h0000;
            len <= 16'h0000;
            sum <= 8'h00;
        end else if (acc) begin
            idx <= out_last ? 16'h0000 : idx + 16'h0001;
            if (idx == 16'h0001) len[15:8] <= out_data;
            if (idx == 16'h0002) len[7:0] <= out_data;
            sum <= (idx < 16'h0003) ? 8'h00 : sum + out_data;
        end
    end
    sequence take_s;
        pkt_start && pkt_start_ready && !out_valid;
    endsequence
    sequence delim_s;
        out_valid && out_data == 8'h7E;
    endsequence
    delim_start_a: assert property (take_s |-> ##2 delim_s)
        else $error("delimiter late");
    ready_drop_a: assert property (
        take_s |=> !pkt_start_ready [*8]) else $error("ready not held low");
    delim_first_a: assert property (
        out_valid && idx == 16'h0000 |-> out_data == 8'h7E)
        else $error("frame start wrong");
    type_byte_a: assert property (
        out_valid && idx == 16'h0003 |-> out_data inside {8'h90, 8'h91})
        else $error("type byte wrong");
    length_field_a: assert property (
        out_valid && out_last |-> idx == len + 16'h0003)
        else $error("length field wrong");
    checksum_byte_a: assert property (
        out_valid && out_last |-> out_data == 8'hFF - sum)
        else $error("checksum wrong");
    stall_hold_a: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_data) && $stable(out_last))
        else $error("output moved while stalled");
    pay_gate_a: assert property (pay_valid && pay_ready |=>
        out_valid && out_data == $past(pay_data))
        else $error("payload byte not passed on");
endmodule // rxf_props

bind rxf_framer rxf_props props_u (.mclk(mclk), .rst_n(rst_n),
    .pkt_start(pkt_start), .pkt_start_ready(pkt_start_ready),
    .pay_ready(pay_ready), .pay_valid(pay_valid), .pay_data(pay_data),
    .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .out_ready(out_ready));

// ---- dv/rxf_sink.sv ----
// host side sink model, stalls at random when asked
`timescale 1ns/1ns
module rxf_sink (
    input wire mclk,
    input wire rst_n,
    input wire stall,
    output logic out_ready
);
    logic [7:0] lfsr;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr <= 8'h5A;
            out_ready <= 1'h0;
        end else begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            out_ready <= !stall || lfsr[0];
        end
    end
endmodule // rxf_sink

// ---- dv/rxf_framer_test.sv ----
// random and corner packets through the framer
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    err_total++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module rxf_framer_test;
    logic mclk = 0, rst_n = 0, fmt = 0, ps = 0, pv = 0, stall = 0;
    logic ack = 0, bc = 0, enc = 0, ed = 0;
    logic [63:0] a64 = 0;
    logic [15:0] a16 = 0, cl = 0, pr = 0, plen = 0;
    logic [7:0] se = 0, de = 0, pd = 0;
    wire psr, pyr, ov, ol, ordy;
    wire [7:0] od;
    int err_total = 0, n_compared = 0;
    bit [31:0] st = 71;
    logic [7:0] exq[$], got[$], pq[$];
    logic lq[$];
    rxf_framer dut_u (.mclk(mclk), .rst_n(rst_n),
        .rx_indicator_format_select(fmt), .pkt_start(ps),
        .pkt_start_ready(psr), .src_addr64(a64), .src_addr16(a16),
        .src_endpoint(se), .dst_endpoint(de), .cluster_id(cl),
        .profile_id(pr), .opt_ack(ack), .opt_bcast(bc), .opt_enc(enc),
        .opt_enddev(ed), .pay_len(plen), .pay_valid(pv), .pay_data(pd),
        .pay_ready(pyr), .out_valid(ov), .out_data(od), .out_last(ol),
        .out_ready(ordy));
    rxf_sink sink_u (.mclk(mclk), .rst_n(rst_n), .stall(stall),
        .out_ready(ordy));
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) begin
        if (ov && ordy) begin
            got.push_back(od);
            lq.push_back(ol);
        end
    end
    function automatic bit [31:0] rnd();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction
    task automatic put(input bit [63:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) exq.push_back(v[8*i+:8]);
    endtask
    task automatic pkt(input int t, input int n);
        bit [7:0] s;
        s = 0;
        got = {};
        lq = {};
        exq = {};
        pq = {};
        repeat (n) pq.push_back(8'(rnd()));
        {a64, a16, cl} <= {rnd(), rnd(), rnd()};
        {pr, se, de} <= rnd();
        plen <= 16'(n);
        ps <= 1;
        do @(posedge mclk); while (!psr);
        ps <= 0;
        put(8'h7E, 1);
        put(n + (fmt ? 18 : 12), 2);
        put(fmt ? 8'h91 : 8'h90, 1);
        put(a64, 8);
        put(a16, 2);
        if (fmt) put({se, de, cl, pr}, 6);
        put({1'h0, ed && !fmt, enc, 3'h0, bc, ack}, 1);
        foreach (pq[k]) put(pq[k], 1);
        for (int i = 3; i < exq.size(); i++) s += exq[i];
        put(8'hFF - s, 1);
        foreach (pq[k]) begin
            pd <= pq[k];
            pv <= 1;
            do @(posedge mclk); while (!pyr);
            if (rnd() % 3 == 0) begin
                pv <= 0;
                @(posedge mclk);
            end
        end
        pv <= 0;
        repeat (300) if (got.size() < exq.size()) @(posedge mclk);
        `CHK("frame size", exq.size(), got.size())
        foreach (exq[i]) `CHK("frame byte", exq[i], got[i])
        foreach (exq[i]) `CHK("last flag", 1'(i == exq.size() - 1), lq[i])
        $display("packet %0d done", t);
    endtask
    task summarize();
        $display("compares %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #40000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1;
        // first two: empty payload, every flag, both formats
        for (int t = 0; t < 40; t++) begin
            fmt <= t < 2 ? t[0] : 1'(rnd());
            {ack, bc, enc, ed} <= t < 2 ? 4'hF : 4'(rnd());
            stall <= t > 3 ? 1'(rnd()) : 1'h0;
            pkt(t, t < 2 ? 0 : rnd() % 9);
        end
        summarize();
    end
endmodule // rxf_framer_test
